// ===== rtl/tia_pkg.sv
package tia_pkg;
   // bit positions in the top-level status and enable vectors
   localparam int ST_PIN   = 0;                 // summary of pin events
   localparam int ST_TIMER = 1;                 // timer wrap
   localparam int ST_SOFT  = 2;                 // software request
   localparam int ST_READY = 3;                 // device ready
   localparam int ST_PHY1  = 4;                 // port one phy summary
   localparam int ST_PHY2  = 5;                 // port two phy summary
   localparam int ST_W     = 6;                 // status vector width

   // documented source sizes
   localparam int PIN_N    = 6;                 // general purpose pins
   localparam int PHY_EV_W = 7;                 // phy event flags per port
   localparam int TIMER_W  = 16;                // timer count width
   localparam logic [15:0] TIMER_ZERO = 16'h0000; // count before wrap
   localparam logic [15:0] TIMER_WRAP = 16'hFFFF; // count after wrap

   // reset values
   localparam logic [5:0] STS_RST = 6'h00;      // top status after reset
   localparam logic [5:0] PIN_RST = 6'h00;      // pin status after reset

   // hold-off timing
   localparam int HOLD_W       = 8;             // interval field width
   localparam int CLK_NS       = 10;            // clock period
   localparam int HOLD_UNIT_NS = 10000;         // one interval step, 10 us
   localparam int HOLD_UNIT_CYC = (HOLD_UNIT_NS + CLK_NS - 1) / CLK_NS; // cycles per step

   // pin output state machine
   typedef enum logic [2:0] {
      TIA_IDLE   = 3'b001,                      // pin inactive, free to assert
      TIA_ACTIVE = 3'b010,                      // pin asserted
      TIA_HOLD   = 3'b100                       // forced inactive after deassert
   } tia_irq_state_t;
endpackage

// ===== rtl/tia_hold_if.sv
`timescale 1ns/1ps
interface tia_hold_if;
   logic                       start;           // one-cycle pulse: pin just deasserted
   logic [tia_pkg::HOLD_W-1:0] interval;        // hold length in steps
   logic                       busy;            // hold-off running

   modport ctrl  (output start, output interval, input busy);
   modport timer (input start, input interval, output busy);
endinterface

// ===== rtl/tia_hold_timer.sv
`timescale 1ns/1ps
module tia_hold_timer #(
   parameter int UNIT_CYC = tia_pkg::HOLD_UNIT_CYC  // cycles per interval step
) (
   input  wire logic clk,                       // system clock
   input  wire logic rstn,                      // async reset, active low
   tia_hold_if.timer hold                       // start, interval and busy
);
   import tia_pkg::*;

   localparam int PW = $clog2(UNIT_CYC + 1);   // prescaler width

   if (UNIT_CYC < 1) begin : g_chk
      $error("tia_hold_timer: UNIT_CYC must be at least 1");
   end

   logic [PW-1:0]     pre_q;                    // step prescaler
   logic [HOLD_W-1:0] cnt_q;                    // steps still to wait
   logic              busy_q;                   // hold-off active

   // prescaler restarts on start so the first step is a full one
   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         pre_q <= '0;
      end else if (hold.start || !busy_q || pre_q == PW'(UNIT_CYC - 1)) begin
         pre_q <= '0;
      end else begin
         pre_q <= pre_q + PW'(1);
      end
   end

   // step counter; a zero interval never starts
   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         cnt_q  <= '0;
         busy_q <= 1'b0;
      end else if (hold.start) begin
         cnt_q  <= hold.interval;
         busy_q <= (hold.interval != '0);
      end else if (busy_q && pre_q == PW'(UNIT_CYC - 1)) begin
         cnt_q  <= cnt_q - HOLD_W'(1);
         busy_q <= (cnt_q != HOLD_W'(1));
      end
   end

   assign hold.busy = busy_q;
endmodule

// ===== rtl/tia_top.sv
// Contract
// - each pin has own enable and status
// - enabled pin status sets pin summary bit
// - pin irq needs pin, summary, global enables
// - timer status sets on wrap zero to FFFFh
// - timer status clears only by writing one
// - timer irq needs run, timer, global enables
// - soft status sets when soft enable set
// - ready status sets once after reset
// - writing one clears ready, zero keeps
// - ready irq needs ready and global enables
// - phy irq needs mask, phy, global enables
// - sub-block summaries clear when source clears
// - hold pin inactive after deassert, zero disables
// - selectable pin polarity and open-drain drive
`timescale 1ns/1ps
module tia_top #(
   parameter int PIN_N     = tia_pkg::PIN_N,        // number of pin sources
   parameter int PHY_EV_W  = tia_pkg::PHY_EV_W,     // phy flags per port
   parameter int UNIT_CYC  = tia_pkg::HOLD_UNIT_CYC // cycles per hold step
) (
   input  wire logic                        clk,                  // system clock
   input  wire logic                        rstn,                 // async reset, active low
   input  wire logic [PIN_N-1:0]            pin_event_in,         // raw pin event lines
   input  wire logic [PIN_N-1:0]            pin_event_enable,     // per-pin enables
   input  wire logic [PIN_N-1:0]            pin_event_clear,      // write-one-to-clear pin status
   output logic      [PIN_N-1:0]            pin_event_status,     // per-pin sticky status
   input  wire logic [tia_pkg::TIMER_W-1:0] timer_count,          // timer count value
   input  wire logic                        timer_run_enable,     // timer run enable
   input  wire logic [PHY_EV_W-1:0]         port_one_phy_event,   // port one event flags
   input  wire logic [PHY_EV_W-1:0]         port_one_phy_mask,    // port one event mask
   input  wire logic [PHY_EV_W-1:0]         port_two_phy_event,   // port two event flags
   input  wire logic [PHY_EV_W-1:0]         port_two_phy_mask,    // port two event mask
   input  wire logic [tia_pkg::ST_W-1:0]    top_interrupt_enable, // per-bit top enables
   input  wire logic [tia_pkg::ST_W-1:0]    top_status_clear,     // write-one-to-clear top bits
   input  wire logic                        irq_output_enable,    // global output enable
   input  wire logic                        irq_polarity_high,    // 1: asserted level high
   input  wire logic                        irq_open_drain,       // 1: open-drain drive
   input  wire logic [tia_pkg::HOLD_W-1:0]  deassert_hold_interval, // hold length in steps
   output logic      [tia_pkg::ST_W-1:0]    top_interrupt_status, // top-level status
   output logic                             irq_pin_o,            // pin output level
   output logic                             irq_pin_oe_n          // pin drive, low drives
);
   import tia_pkg::*;

   if (PIN_N < 1 || PIN_N > 32 || PHY_EV_W < 1 || UNIT_CYC < 1) begin : g_chk
      $error("tia_top: unsupported parameter value");
   end

   logic [PIN_N-1:0] pin_s1_q;                  // first sync stage
   logic [PIN_N-1:0] pin_s2_q;                  // second sync stage
   logic [PIN_N-1:0] pin_s3_q;                  // edge history
   logic [PIN_N-1:0] pin_rise;                  // synchronised rising edge
   logic [PIN_N-1:0] pin_sts_q;                 // per-pin sticky status
   logic [ST_W-1:0]  sts_q;                     // top status register
   logic [ST_W-1:0]  sts_d;                     // top status next value
   logic [TIMER_W-1:0] cnt_prev_q;              // timer count last cycle
   logic             timer_wrap;                // wrap past zero seen
   logic             boot_q;                    // high from first edge after reset
   logic [ST_W-1:0]  en_eff;                    // enables incl. timer run gate
   logic             irq_req;                   // gated interrupt request
   tia_irq_state_t   state_q;                   // pin state
   tia_irq_state_t   state_d;                   // pin next state
   logic             irq_o_q;                   // pin level register
   logic             irq_oe_n_q;                // pin drive register

   tia_hold_if hold_bus ();                     // link to hold-off timer

   // pin synchroniser, two flops then edge history
   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         pin_s1_q <= '0;
         pin_s2_q <= '0;
         pin_s3_q <= '0;
      end else begin
         pin_s1_q <= pin_event_in;
         pin_s2_q <= pin_s1_q;
         pin_s3_q <= pin_s2_q;
      end
   end

   assign pin_rise = pin_s2_q & ~pin_s3_q;

   // per-pin sticky status, set beats clear
   for (genvar i = 0; i < PIN_N; i++) begin : g_pin
      always_ff @(posedge clk or negedge rstn) begin
         if (!rstn) begin
            pin_sts_q[i] <= 1'b0;
         end else if (pin_rise[i]) begin
            pin_sts_q[i] <= 1'b1;
         end else if (pin_event_clear[i]) begin
            pin_sts_q[i] <= 1'b0;
         end
      end
   end

   // timer count history for wrap detection
   // resets to FFFFh so a timer parked there shows no false wrap
   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         cnt_prev_q <= TIMER_WRAP;
      end else begin
         cnt_prev_q <= timer_count;
      end
   end

   assign timer_wrap = (cnt_prev_q == TIMER_ZERO) && (timer_count == TIMER_WRAP);

   // marks the first edge after reset release
   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         boot_q <= 1'b0;
      end else begin
         boot_q <= 1'b1;
      end
   end

   // top status next value
   always_comb begin
      sts_d = sts_q;
      // summaries follow their source, no clear here
      sts_d[ST_PIN]  = |(pin_sts_q & pin_event_enable);
      sts_d[ST_PHY1] = |(port_one_phy_event & port_one_phy_mask);
      sts_d[ST_PHY2] = |(port_two_phy_event & port_two_phy_mask);
      // timer: sticky, write one clears, wrap wins
      if (timer_wrap) begin
         sts_d[ST_TIMER] = 1'b1;
      end else if (top_status_clear[ST_TIMER]) begin
         sts_d[ST_TIMER] = 1'b0;
      end
      // soft request raised by its enable
      if (top_interrupt_enable[ST_SOFT]) begin
         sts_d[ST_SOFT] = 1'b1;
      end else if (top_status_clear[ST_SOFT]) begin
         sts_d[ST_SOFT] = 1'b0;
      end
      // ready raised once at first edge after reset
      if (!boot_q) begin
         sts_d[ST_READY] = 1'b1;
      end else if (top_status_clear[ST_READY]) begin
         sts_d[ST_READY] = 1'b0;
      end
   end

   // top status register
   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         sts_q <= STS_RST;
      end else begin
         sts_q <= sts_d;
      end
   end

   // enables, timer path also needs run enable
   always_comb begin
      en_eff = top_interrupt_enable;
      en_eff[ST_TIMER] = top_interrupt_enable[ST_TIMER] & timer_run_enable;
   end

   assign irq_req = irq_output_enable && |(sts_q & en_eff);

   // hold-off request on deassert
   assign hold_bus.start    = (state_q == TIA_ACTIVE) && !irq_req;
   assign hold_bus.interval = deassert_hold_interval;

   tia_hold_timer #(
      .UNIT_CYC (UNIT_CYC)
   ) u_hold (
      .clk  (clk),
      .rstn (rstn),
      .hold (hold_bus.timer)
   );

   // pin state next value
   always_comb begin
      state_d = state_q;
      unique case (state_q)
         TIA_IDLE: begin
            if (irq_req) begin
               state_d = TIA_ACTIVE;
            end
         end
         TIA_ACTIVE: begin
            if (!irq_req) begin
               // zero interval skips the hold
               state_d = (deassert_hold_interval == '0) ? TIA_IDLE : TIA_HOLD;
            end
         end
         TIA_HOLD: begin
            if (!hold_bus.busy) begin
               state_d = TIA_IDLE;
            end
         end
         default: begin
            state_d = TIA_IDLE;                 // illegal code recovers
         end
      endcase
   end

   // pin state register
   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         state_q <= TIA_IDLE;
      end else begin
         state_q <= state_d;
      end
   end

   // pin drive, polarity and buffer type
   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         irq_o_q    <= 1'b0;
         irq_oe_n_q <= 1'b1;
      end else if (irq_open_drain) begin
         irq_o_q    <= irq_polarity_high;
         irq_oe_n_q <= (state_d != TIA_ACTIVE);
      end else begin
         irq_o_q    <= (state_d == TIA_ACTIVE) ? irq_polarity_high : !irq_polarity_high;
         irq_oe_n_q <= 1'b0;
      end
   end

   assign pin_event_status     = pin_sts_q;
   assign top_interrupt_status = sts_q;
   assign irq_pin_o            = irq_o_q;
   assign irq_pin_oe_n         = irq_oe_n_q;

   // checks
   logic pin_asserted;                          // pin shows asserted level
   assign pin_asserted = !irq_oe_n_q && (irq_o_q == irq_polarity_high);

   sequence s_deassert;
      state_q == TIA_ACTIVE && !irq_req && deassert_hold_interval != '0;
   endsequence

   sequence s_hold_start;
      state_q == TIA_HOLD && hold_bus.busy;
   endsequence

   AST_PIN_SET: assert property (@(posedge clk) disable iff (!rstn)
      (pin_rise != '0) |=> ((pin_sts_q & $past(pin_rise)) == $past(pin_rise)))
      else $error("pin status missed an event");
   AST_PIN_SUM: assert property (@(posedge clk) disable iff (!rstn)
      boot_q |=> sts_q[ST_PIN] == |($past(pin_sts_q) & $past(pin_event_enable)))
      else $error("pin summary does not match enabled pin status");
   AST_TIMER_SET: assert property (@(posedge clk) disable iff (!rstn)
      timer_wrap |=> sts_q[ST_TIMER])
      else $error("timer status not set on wrap");
   AST_TIMER_KEEP: assert property (@(posedge clk) disable iff (!rstn)
      sts_q[ST_TIMER] && !top_status_clear[ST_TIMER] |=> sts_q[ST_TIMER])
      else $error("timer status dropped without a clear");
   AST_SOFT_SET: assert property (@(posedge clk) disable iff (!rstn)
      top_interrupt_enable[ST_SOFT] |=> sts_q[ST_SOFT])
      else $error("soft status not raised by enable");
   AST_READY_BOOT: assert property (@(posedge clk) disable iff (!rstn)
      !boot_q |=> sts_q[ST_READY] && boot_q)
      else $error("ready not set after reset");
   AST_READY_CLR: assert property (@(posedge clk) disable iff (!rstn)
      boot_q && top_status_clear[ST_READY] |=> !sts_q[ST_READY])
      else $error("ready not cleared by writing one");
   AST_READY_KEEP: assert property (@(posedge clk) disable iff (!rstn)
      boot_q && sts_q[ST_READY] && !top_status_clear[ST_READY] |=> sts_q[ST_READY])
      else $error("ready dropped without a clear");
   AST_PHY_SUM: assert property (@(posedge clk) disable iff (!rstn)
      ##1 sts_q[ST_PHY1] == |($past(port_one_phy_event) & $past(port_one_phy_mask)))
      else $error("port one phy summary wrong");
   AST_GATE: assert property (@(posedge clk) disable iff (!rstn)
      state_q == TIA_IDLE && !irq_req |=> state_q != TIA_ACTIVE)
      else $error("pin asserted without a gated request");
   AST_GLOBAL_OFF: assert property (@(posedge clk) disable iff (!rstn)
      !irq_output_enable[*2] |-> ##1 !pin_asserted)
      else $error("pin asserted with output disabled");
   AST_HOLD: assert property (@(posedge clk) disable iff (!rstn)
      s_deassert |=> s_hold_start ##1 (!pin_asserted)[*3])
      else $error("hold-off not applied after deassert");
   AST_DRIVE: assert property (@(posedge clk) disable iff (!rstn)
      !irq_open_drain |=> !irq_oe_n_q ##0 (irq_o_q != (state_q == TIA_ACTIVE ? !irq_polarity_high
                                                      : irq_polarity_high) || $changed(irq_polarity_high)))
      else $error("push-pull level wrong");

   // further summary, clear, gating, drive and hold checks
   AST_PHY2_SUM: assert property (@(posedge clk) disable iff (!rstn)
      ##1 sts_q[ST_PHY2] == |($past(port_two_phy_event) & $past(port_two_phy_mask)))
      else $error("port two phy summary wrong");
   AST_TIMER_CLR: assert property (@(posedge clk) disable iff (!rstn)
      !timer_wrap && top_status_clear[ST_TIMER] |=> !sts_q[ST_TIMER])
      else $error("timer status not cleared by writing one");
   AST_TIMER_GATE: assert property (@(posedge clk) disable iff (!rstn)
      !timer_run_enable && (sts_q & top_interrupt_enable & ~(ST_W'(1) << ST_TIMER)) == '0 |-> !irq_req)
      else $error("timer request passed without run enable");
   AST_READY_GATE: assert property (@(posedge clk) disable iff (!rstn)
      irq_output_enable && sts_q[ST_READY] && top_interrupt_enable[ST_READY] |-> irq_req)
      else $error("enabled ready status did not request");
   AST_SUM_NO_CLR: assert property (@(posedge clk) disable iff (!rstn)
      top_status_clear[ST_PIN] && (pin_sts_q & pin_event_enable) != '0 |=> sts_q[ST_PIN])
      else $error("pin summary cleared while source still flagged");
   AST_OD_RELEASE: assert property (@(posedge clk) disable iff (!rstn)
      irq_open_drain |=> irq_oe_n_q == (state_q != TIA_ACTIVE) && irq_o_q == $past(irq_polarity_high))
      else $error("open-drain drive wrong");
   AST_HOLD_ZERO: assert property (@(posedge clk) disable iff (!rstn)
      state_q == TIA_ACTIVE && !irq_req && deassert_hold_interval == '0 |=> state_q == TIA_IDLE)
      else $error("zero interval still held the pin");
   AST_REQ_ASSERT: assert property (@(posedge clk) disable iff (!rstn)
      state_q == TIA_IDLE && irq_req |=> state_q == TIA_ACTIVE && (pin_asserted || $changed(irq_polarity_high)))
      else $error("gated request did not assert the pin");
endmodule

// ===== verification/tia_host_model.sv
`timescale 1ns/1ps
// host end of the shared request line
module tia_host_model (
   input  wire logic irq_pin_o,    // level driven by the block
   input  wire logic irq_pin_oe_n, // low while the block drives
   input  wire logic pol_high,     // asserted level the host expects
   output logic      irq_wire,     // resolved line level
   output logic      irq_seen      // host sees a request
);
   // a released line is pulled to the inactive level
   assign irq_wire = irq_pin_oe_n ? ~pol_high : irq_pin_o;
   // request seen only at the asserted level
   // plain equality lets an unknown level reach the checks
   assign irq_seen = (irq_wire == pol_high);
endmodule

// ===== verification/tb_top_level_interrupt_aggregator.sv
`timescale 1ns/1ps
module tb_top_level_interrupt_aggregator;
   import tia_pkg::*;
   localparam int UCYC = 3;              // shortened hold step
   logic        clk = 1'b0;              // system clock
   logic        rstn;                    // reset, active low
   logic [5:0]  pin_in, pin_en, pin_clr; // pin sources
   logic [5:0]  pin_sts;                 // pin status seen
   logic [15:0] cnt;                     // timer count
   logic        run;                     // timer run enable
   logic [6:0]  ev1, mk1, ev2, mk2;      // phy flags and masks
   logic [5:0]  top_en, clr, sts;        // top enables, clears, status
   logic        gen, pol, od;            // output configuration
   logic [7:0]  hold;                    // hold interval
   logic        pin_o, oe_n;             // pin drive
   logic        irq_wire, irq_seen;      // host view
   int          error_cnt = 0;           // mismatches
   int          tests_run = 0;           // comparisons

   // 100 MHz clock
   always #5 clk = ~clk;

   tia_top #(.UNIT_CYC(UCYC)) i_tia_top (
      .clk(clk), .rstn(rstn), .pin_event_in(pin_in), .pin_event_enable(pin_en),
      .pin_event_clear(pin_clr), .pin_event_status(pin_sts), .timer_count(cnt),
      .timer_run_enable(run), .port_one_phy_event(ev1), .port_one_phy_mask(mk1),
      .port_two_phy_event(ev2), .port_two_phy_mask(mk2), .top_interrupt_enable(top_en),
      .top_status_clear(clr), .irq_output_enable(gen), .irq_polarity_high(pol),
      .irq_open_drain(od), .deassert_hold_interval(hold), .top_interrupt_status(sts),
      .irq_pin_o(pin_o), .irq_pin_oe_n(oe_n));

   tia_host_model i_tia_host_model (
      .irq_pin_o(pin_o), .irq_pin_oe_n(oe_n), .pol_high(pol),
      .irq_wire(irq_wire), .irq_seen(irq_seen));

   // advance n edges, then settle
   task automatic step(input int n);
      repeat (n) @(posedge clk);
      #1;
   endtask

   // compare and count
   task automatic chk(input string nm, input logic [5:0] e, input logic [5:0] g);
      tests_run++;
      if (g !== e) begin
         error_cnt++;
         $display("[ERR] %s expected %h seen %h", nm, e, g);
      end
   endtask

   // host view of the request
   task automatic chk_irq(input logic e);
      chk("irq", {5'h00, e}, {5'h00, irq_seen});
   endtask

   // one-cycle write-one-to-clear of top bits
   task automatic top_clear(input logic [5:0] m);
      clr = m;
      step(1);
      clr = 6'h00;
   endtask

   // verdict and end of run
   task automatic close_out();
      $display("checks %0d mismatches %0d", tests_run, error_cnt);
      if (error_cnt == 0 && tests_run > 0) begin
         $display("SIMULATION PASSED");
      end else begin
         $display("SIMULATION FAILED");
      end
      $finish;
   endtask

   // watchdog against a hang
   initial begin
      repeat (5000) @(posedge clk);
      error_cnt++;
      close_out();
   end

   // main sequence
   initial begin
      rstn = 1'b0; pin_in = 6'h00; pin_en = 6'h00; pin_clr = 6'h00; cnt = 16'h0001; run = 1'b0;
      ev1 = 7'h00; mk1 = 7'h7F; ev2 = 7'h00; mk2 = 7'h7F; top_en = 6'h00; clr = 6'h00;
      gen = 1'b0; pol = 1'b1; od = 1'b0; hold = 8'h00;
      repeat (5) @(posedge clk);
      #1 rstn = 1'b1;
      step(2);
      chk("status", 6'h08, sts);
      top_clear(6'h02);
      step(1);
      chk("status", 6'h08, sts);
      top_en = 6'h08;
      step(3);
      chk_irq(1'b0);
      gen = 1'b1;
      step(3);
      chk_irq(1'b1);
      top_clear(6'h08);
      step(3);
      chk("status", 6'h00, sts);
      chk_irq(1'b0);
      $display("test ready done");
      // soft request under every output mode
      for (int m = 0; m < 4; m++) begin
         pol = m[0]; od = m[1]; top_en = 6'h04;
         step(3);
         chk("status", 6'h04, sts);
         chk_irq(1'b1);
         chk("oe_n", 6'h00, {5'h00, oe_n});
         gen = 1'b0;
         step(3);
         chk_irq(1'b0);
         chk("oe_n", {5'h00, od}, {5'h00, oe_n});
         gen = 1'b1; top_en = 6'h00;
         top_clear(6'h04);
         step(1);
      end
      $display("test soft done");
      // wrap detection and its gating
      top_en = 6'h02; cnt = 16'h0000;
      step(1);
      cnt = 16'h0001;
      step(1);
      cnt = 16'hFFFF;
      step(2);
      chk("status", 6'h00, sts);
      cnt = 16'h0000;
      step(1);
      cnt = 16'hFFFF;
      step(3);
      chk("status", 6'h02, sts);
      chk_irq(1'b0);
      run = 1'b1;
      step(3);
      chk_irq(1'b1);
      chk("status", 6'h02, sts);
      top_clear(6'h02);
      step(2);
      chk("status", 6'h00, sts);
      chk_irq(1'b0);
      run = 1'b0;
      $display("test timer done");
      // each pin source
      top_en = 6'h01;
      for (int p = 0; p < 6; p++) begin
         pin_in = 6'h01 << p; pin_en = 6'h00;
         step(6);
         chk("pin", 6'h01 << p, pin_sts);
         chk("status", 6'h00, sts);
         chk_irq(1'b0);
         pin_en = 6'h01 << p;
         step(3);
         chk("status", 6'h01, sts);
         chk_irq(1'b1);
         top_clear(6'h01);
         step(1);
         chk("status", 6'h01, sts);
         pin_clr = 6'h01 << p;
         step(1);
         pin_clr = 6'h00; pin_in = 6'h00;
         step(3);
         chk("status", 6'h00, sts);
         chk_irq(1'b0);
      end
      $display("test pins done");
      // both phy summaries
      for (int q = 0; q < 2; q++) begin
         ev1 = q ? 7'h00 : 7'h40; ev2 = q ? 7'h40 : 7'h00; mk1 = 7'h3F; mk2 = 7'h3F;
         top_en = 6'h30;
         step(3);
         chk_irq(1'b0);
         mk1 = 7'h7F; mk2 = 7'h7F; top_en = q ? 6'h10 : 6'h20;
         step(3);
         chk_irq(1'b0);
         top_en = 6'h30;
         step(3);
         chk("status", q ? 6'h20 : 6'h10, sts);
         chk_irq(1'b1);
         top_clear(6'h30);
         step(1);
         chk("status", q ? 6'h20 : 6'h10, sts);
         ev1 = 7'h00; ev2 = 7'h00;
         step(3);
         chk("status", 6'h00, sts);
      end
      $display("test phy done");
      // deassert hold-off, then disabled
      hold = 8'h02; top_en = 6'h04;
      step(3);
      chk_irq(1'b1);
      gen = 1'b0;
      step(1);
      gen = 1'b1;
      step(2);
      chk_irq(1'b0);
      step(3);
      chk_irq(1'b0);
      for (int w = 0; w < 12 && irq_seen !== 1'b1; w++) step(1);
      chk_irq(1'b1);
      hold = 8'h00; gen = 1'b0;
      step(1);
      gen = 1'b1;
      step(2);
      chk_irq(1'b1);
      $display("test hold done");
      // reset in mid-run with the timer parked at FFFFh
      top_en = 6'h00; rstn = 1'b0;
      step(1);
      chk("oe_n", 6'h01, {5'h00, oe_n});
      chk("status", 6'h00, sts);
      rstn = 1'b1;
      step(1);
      chk("status", 6'h08, sts);
      $display("test reset done");
      close_out();
   end
endmodule
